// ===== vlk_pkg.sv
// Constants shared by the VLAN lookup and table access ends.
package vlk_pkg;
  localparam logic [7:0] REG_CTRL = 8'h6e;
  localparam logic [7:0] REG_INDEX = 8'h6f;
  localparam logic [7:0] REG_DATA_TOP = 8'h70;
  localparam logic [7:0] REG_DATA_PMID = 8'h72;
  localparam logic [7:0] REG_DATA_B23 = 8'h76;
  localparam logic [7:0] REG_DATA_B7 = 8'h78;
  localparam int CTRL_RD_BIT = 4;
  localparam int CTRL_TBL_LSB = 2;
  localparam logic [1:0] TBL_STATIC = 2'h0;
  localparam logic [1:0] TBL_VLAN = 2'h1;
  localparam logic [1:0] TBL_DYN = 2'h2;
  localparam int VLAN_ENTRIES = 16;
  localparam int VLAN_W = 22;
  localparam int VLAN_VALID_BIT = 21;
  localparam int VLAN_MEMB_LSB = 16;
  localparam int VLAN_FID_LSB = 12;
  localparam logic [21:0] VLAN_RESET = {1'b1, 5'h1f, 4'h0, 12'h001};
  localparam int REC_W = 69;
  localparam int REC_NOTREADY_BIT = 55;
  localparam int BYTE_NOTREADY_BIT = 7;
  localparam int DYN_DEPTH_DEF = 1024;
  localparam int PORTS = 5;
  localparam logic [1:0] STAMP_MAX = 2'h3;
  localparam logic [7:0] AXI_CTRL = 8'h00;
  localparam logic [7:0] AXI_INDEX = 8'h04;
  localparam logic [7:0] AXI_WDATA = 8'h08;
  localparam logic [7:0] AXI_REC_LO = 8'h0c;
  localparam logic [7:0] AXI_REC_MID = 8'h10;
  localparam logic [7:0] AXI_REC_HI = 8'h14;
  localparam logic [7:0] AXI_STATUS = 8'h18;
  localparam int CLK_MHZ = 100;
  localparam int AGE_PERIOD_US = 10000;
  localparam int AGE_CYCLES_DEF = AGE_PERIOD_US * CLK_MHZ;
endpackage : vlk_pkg

// ===== vlk_mgmt_if.sv
// Byte-wide management register port joining the host end and the device end.
`timescale 1ns/10ps
interface vlk_mgmt_if;
  logic [7:0] mgmt_addr;
  logic mgmt_wr;
  logic mgmt_rd;
  logic [7:0] mgmt_wdata;
  logic [7:0] mgmt_rdata;
  logic mgmt_rvalid;
  modport dev (input mgmt_addr, input mgmt_wr, input mgmt_rd, input mgmt_wdata,
               output mgmt_rdata, output mgmt_rvalid);
  modport host (output mgmt_addr, output mgmt_wr, output mgmt_rd, output mgmt_wdata,
                input mgmt_rdata, input mgmt_rvalid);
endinterface : vlk_mgmt_if

// ===== vlk_vlan_entry.sv
// One VLAN table entry with its reset default.
`timescale 1ns/10ps
module vlk_vlan_entry (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic [21:0] wr_data,
  output logic [21:0] entry
);
  logic [21:0] entry_reg;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      entry_reg <= vlk_pkg::VLAN_RESET;
    end else if (wr_en) begin
      entry_reg <= wr_data;
    end
  end
  assign entry = entry_reg;
endmodule : vlk_vlan_entry

// ===== vlk_device.sv
// Device end: VLAN table, dynamic address table, lookup and indirect register access.
//
// Contract
// - VLAN table used only when VLAN enabled.
// - Entry holds valid, membership, filter_id, vlan_ident.
// - Entries reset valid, all members, identifier one.
// - Membership bit zero is port one.
// - Untagged or null tag takes port default.
// - Non-null tag identifier is used as is.
// - Invalid VLAN drops packet without learning.
// - Valid VLAN gives filter_id for both lookups.
// - Destination miss floods members except ingress.
// - Source miss learns pair into dynamic table.
// - Host reads VLAN entry via control, index.
// - Host writes data, control, then index.
// - Dynamic table changed only by device.
// - Dynamic read returns the 69-bit record.
// - Count field is valid entries minus one.
// - Empty flag set when no entries, reset.
// - Not-ready bit set until record captured.
// - Source port coded zero to four.
// - Each entry has two-bit aging stamp.
// - Host dynamic read by select, index, bytes.
// - Host may start reading at bits 55-48.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module vlk_device #(
  parameter int DYN_DEPTH = vlk_pkg::DYN_DEPTH_DEF,
  parameter int AGE_CYCLES = vlk_pkg::AGE_CYCLES_DEF
) (
  input wire logic core_clk,
  input wire logic reset,
  vlk_mgmt_if.dev mgmt,
  input wire logic vlan_enable,
  input wire logic [59:0] port_default_vid,
  input wire logic pkt_valid,
  input wire logic [2:0] pkt_port,
  input wire logic pkt_tagged,
  input wire logic [11:0] pkt_tag_vid,
  input wire logic [47:0] pkt_da,
  input wire logic [47:0] pkt_sa,
  input wire logic static_hit,
  input wire logic [4:0] static_ports,
  output logic res_valid,
  output logic res_drop,
  output logic [4:0] res_ports,
  output logic [11:0] res_vid,
  output logic res_learn
);
  localparam int AW = $clog2(DYN_DEPTH);

  logic [7:0] ctrl_reg, index_reg, rdata_reg;
  logic [71:0] rec_reg;
  logic dyn_pend_reg, rvalid_reg, age_tick, trigger, trig_rd;
  logic [9:0] dyn_idx_reg, trig_idx;
  logic [21:0] vlan_entry [vlk_pkg::VLAN_ENTRIES];
  logic [vlk_pkg::VLAN_ENTRIES-1:0] vlan_wr;
  logic dyn_valid [DYN_DEPTH];
  logic [47:0] dyn_mac [DYN_DEPTH];
  logic [3:0] dyn_fid [DYN_DEPTH];
  logic [2:0] dyn_port [DYN_DEPTH];
  logic [1:0] dyn_stamp [DYN_DEPTH];
  logic [10:0] count_reg;
  logic [AW-1:0] age_ptr_reg;
  logic [31:0] age_div_reg;
  logic [1:0] trig_tbl;

  // Control byte and index byte; the index write starts the access.
  assign trigger = mgmt.mgmt_wr && (mgmt.mgmt_addr == vlk_pkg::REG_INDEX);
  assign trig_idx = {ctrl_reg[1:0], mgmt.mgmt_wdata};
  assign trig_tbl = ctrl_reg[vlk_pkg::CTRL_TBL_LSB +: 2];
  assign trig_rd = ctrl_reg[vlk_pkg::CTRL_RD_BIT];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= 8'h00;
      index_reg <= 8'h00;
    end else if (mgmt.mgmt_wr) begin
      if (mgmt.mgmt_addr == vlk_pkg::REG_CTRL) begin
        ctrl_reg <= mgmt.mgmt_wdata;
      end
      if (mgmt.mgmt_addr == vlk_pkg::REG_INDEX) begin
        index_reg <= mgmt.mgmt_wdata;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < vlk_pkg::VLAN_ENTRIES; gi++) begin : g_vlan
      assign vlan_wr[gi] = trigger && !trig_rd && (trig_tbl == vlk_pkg::TBL_VLAN) &&
                           (trig_idx == 10'(gi));
      vlk_vlan_entry u_entry (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(vlan_wr[gi]),
        .wr_data(rec_reg[vlk_pkg::VLAN_W-1:0]),
        .entry(vlan_entry[gi])
      );
    end
  endgenerate

  // Record assembly for a dynamic read, built from the entry and the table count.
  logic [vlk_pkg::REC_W-1:0] dyn_record;
  logic [AW-1:0] rd_slot;
  assign rd_slot = AW'(dyn_idx_reg);
  assign dyn_record = {(count_reg == 11'h000),
                       (count_reg == 11'h000) ? 10'h000 : 10'(count_reg - 11'h001),
                       dyn_stamp[rd_slot], 1'b0, dyn_port[rd_slot], dyn_fid[rd_slot],
                       dyn_mac[rd_slot]};

  // Data bytes: host stores write data here, reads load it; the dynamic read lands one cycle later.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rec_reg <= 72'h0;
      dyn_pend_reg <= 1'b0;
      dyn_idx_reg <= 10'h000;
    end else if (dyn_pend_reg) begin
      rec_reg <= {3'h0, dyn_record};
      dyn_pend_reg <= 1'b0;
    end else if (trigger && trig_rd && trig_tbl == vlk_pkg::TBL_VLAN) begin
      rec_reg <= {50'h0, vlan_entry[trig_idx[3:0]]};
    end else if (trigger && trig_rd && trig_tbl == vlk_pkg::TBL_DYN) begin
      rec_reg[vlk_pkg::REC_W-1:vlk_pkg::REC_NOTREADY_BIT+1] <= dyn_record[vlk_pkg::REC_W-1:vlk_pkg::REC_NOTREADY_BIT+1];
      rec_reg[vlk_pkg::REC_NOTREADY_BIT] <= 1'b1;
      dyn_pend_reg <= 1'b1;
      dyn_idx_reg <= trig_idx;
    end else if (mgmt.mgmt_wr && mgmt.mgmt_addr >= vlk_pkg::REG_DATA_TOP &&
                 mgmt.mgmt_addr <= vlk_pkg::REG_DATA_B7) begin
      rec_reg[8'(vlk_pkg::REG_DATA_B7 - mgmt.mgmt_addr) * 8 +: 8] <= mgmt.mgmt_wdata;
    end
  end

  // Register read answer, one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= mgmt.mgmt_rd;
      if (mgmt.mgmt_rd) begin
        if (mgmt.mgmt_addr == vlk_pkg::REG_CTRL) begin
          rdata_reg <= ctrl_reg;
        end else if (mgmt.mgmt_addr == vlk_pkg::REG_INDEX) begin
          rdata_reg <= index_reg;
        end else if (mgmt.mgmt_addr >= vlk_pkg::REG_DATA_TOP && mgmt.mgmt_addr <= vlk_pkg::REG_DATA_B7) begin
          rdata_reg <= rec_reg[8'(vlk_pkg::REG_DATA_B7 - mgmt.mgmt_addr) * 8 +: 8];
        end else begin
          rdata_reg <= 8'h00;
        end
      end
    end
  end
  assign mgmt.mgmt_rdata = rdata_reg;
  assign mgmt.mgmt_rvalid = rvalid_reg;

  // Identifier assignment and VLAN table search.
  logic [11:0] vlan_ident;
  logic [21:0] hit_entry;
  logic vlan_ok;
  logic [3:0] filter_id;
  logic [4:0] members;
  always_comb begin
    if (pkt_tagged && pkt_tag_vid != 12'h000) begin
      vlan_ident = pkt_tag_vid;
    end else begin
      vlan_ident = port_default_vid[pkt_port * 12 +: 12];
    end
    hit_entry = 22'h0;
    for (int i = vlk_pkg::VLAN_ENTRIES - 1; i >= 0; i--) begin
      if (vlan_entry[i][11:0] == vlan_ident) begin
        hit_entry = vlan_entry[i];
      end
    end
    if (vlan_enable) begin
      vlan_ok = hit_entry[vlk_pkg::VLAN_VALID_BIT];
      filter_id = hit_entry[vlk_pkg::VLAN_FID_LSB +: 4];
      members = hit_entry[vlk_pkg::VLAN_MEMB_LSB +: vlk_pkg::PORTS];
    end else begin
      vlan_ok = 1'b1;
      filter_id = 4'h0;
      members = 5'h1f;
    end
  end

  // Direct-mapped table: a key's slot is its address folded with its filter_id.
  logic [AW-1:0] da_slot, sa_slot;
  logic da_hit, sa_hit, learn;
  logic [4:0] ingress_bit, fwd;
  assign da_slot = pkt_da[AW-1:0] ^ AW'(filter_id);
  assign sa_slot = pkt_sa[AW-1:0] ^ AW'(filter_id);
  assign da_hit = dyn_valid[da_slot] && dyn_mac[da_slot] == pkt_da && dyn_fid[da_slot] == filter_id;
  assign sa_hit = dyn_valid[sa_slot] && dyn_mac[sa_slot] == pkt_sa && dyn_fid[sa_slot] == filter_id;
  assign learn = pkt_valid && vlan_ok;
  assign ingress_bit = 5'(5'h01 << pkt_port);
  always_comb begin
    if (static_hit) begin
      fwd = static_ports;
    end else if (da_hit) begin
      fwd = 5'(5'h01 << dyn_port[da_slot]);
    end else begin
      fwd = members;
    end
    fwd = fwd & ~ingress_bit;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      res_valid <= 1'b0;
      res_drop <= 1'b0;
      res_ports <= 5'h00;
      res_vid <= 12'h000;
      res_learn <= 1'b0;
    end else begin
      res_valid <= pkt_valid;
      res_drop <= pkt_valid && !vlan_ok;
      res_ports <= vlan_ok ? fwd : 5'h00;
      res_vid <= vlan_ident;
      res_learn <= learn && !sa_hit;
    end
  end

  // Aging divider: one tick each period steps a pointer over the table.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      age_div_reg <= 32'h0;
      age_ptr_reg <= '0;
    end else if (age_div_reg == 32'(AGE_CYCLES - 1)) begin
      age_div_reg <= 32'h0;
      age_ptr_reg <= age_ptr_reg + 1'b1;
    end else begin
      age_div_reg <= age_div_reg + 32'h1;
    end
  end
  assign age_tick = (age_div_reg == 32'(AGE_CYCLES - 1));

  // Learning refreshes or creates the source slot; aging wins nothing over a learn in the same slot.
  logic age_hit, age_kill, learn_new;
  assign age_hit = age_tick && !(learn && sa_slot == age_ptr_reg) && dyn_valid[age_ptr_reg];
  assign age_kill = age_hit && dyn_stamp[age_ptr_reg] == vlk_pkg::STAMP_MAX;
  assign learn_new = learn && !dyn_valid[sa_slot];

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DYN_DEPTH; i++) begin
        dyn_valid[i] <= 1'b0;
        dyn_mac[i] <= 48'h0;
        dyn_fid[i] <= 4'h0;
        dyn_port[i] <= 3'h0;
        dyn_stamp[i] <= 2'h0;
      end
    end else begin
      if (age_hit) begin
        dyn_stamp[age_ptr_reg] <= dyn_stamp[age_ptr_reg] + 2'h1;
        dyn_valid[age_ptr_reg] <= !age_kill;
      end
      if (learn) begin
        dyn_valid[sa_slot] <= 1'b1;
        dyn_mac[sa_slot] <= pkt_sa;
        dyn_fid[sa_slot] <= filter_id;
        dyn_port[sa_slot] <= pkt_port;
        dyn_stamp[sa_slot] <= 2'h0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_reg <= 11'h000;
    end else begin
      count_reg <= count_reg + 11'(learn_new) - 11'(age_kill);
    end
  end
endmodule : vlk_device

// ===== vlk_host.sv
// Host end: AXI4-Lite command registers driving the indirect table access sequences.
`timescale 1ns/10ps
module vlk_host (
  input wire logic core_clk,
  input wire logic reset,
  vlk_mgmt_if.host mgmt,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [2:0] {H_IDLE, H_WDATA, H_CTRL, H_INDEX, H_RDREQ, H_RDWAIT} vlk_hstate_t;
  vlk_hstate_t state_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] index_reg;
  logic [21:0] wdata_reg;
  logic [71:0] rec_reg;
  logic [7:0] addr_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic do_write;
  logic start;
  logic is_dyn;

  assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_rresp = 2'h0;
  assign do_write = aw_have_reg && w_have_reg;
  assign start = do_write && aw_addr_reg == vlk_pkg::AXI_INDEX && w_strb_reg[0] && state_reg == H_IDLE;
  assign is_dyn = ctrl_reg[vlk_pkg::CTRL_TBL_LSB +: 2] == vlk_pkg::TBL_DYN;

  // Address and data are caught in either order; the response follows both.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Command registers are frozen while a sequence runs so the sequence sees stable values.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= 8'h00;
      index_reg <= 8'h00;
      wdata_reg <= 22'h0;
    end else if (do_write && state_reg == H_IDLE && w_strb_reg[0]) begin
      unique case (aw_addr_reg)
        vlk_pkg::AXI_CTRL: ctrl_reg <= w_data_reg[7:0];
        vlk_pkg::AXI_INDEX: index_reg <= w_data_reg[7:0];
        vlk_pkg::AXI_WDATA: wdata_reg <= w_data_reg[21:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      unique case (s_axi_araddr)
        vlk_pkg::AXI_CTRL: s_axi_rdata <= {24'h0, ctrl_reg};
        vlk_pkg::AXI_INDEX: s_axi_rdata <= {24'h0, index_reg};
        vlk_pkg::AXI_WDATA: s_axi_rdata <= {10'h0, wdata_reg};
        vlk_pkg::AXI_REC_LO: s_axi_rdata <= rec_reg[31:0];
        vlk_pkg::AXI_REC_MID: s_axi_rdata <= rec_reg[63:32];
        vlk_pkg::AXI_REC_HI: s_axi_rdata <= {27'h0, rec_reg[68:64]};
        vlk_pkg::AXI_STATUS: s_axi_rdata <= {31'h0, state_reg != H_IDLE};
        default: s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Sequencer: data bytes, control byte, index byte, then reads from high bytes to low.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= H_IDLE;
      addr_reg <= 8'h00;
      rec_reg <= 72'h0;
    end else begin
      unique case (state_reg)
        H_IDLE: if (start) begin
          addr_reg <= vlk_pkg::REG_DATA_B23;
          state_reg <= ctrl_reg[vlk_pkg::CTRL_RD_BIT] ? H_CTRL : H_WDATA;
        end
        H_WDATA: begin
          addr_reg <= addr_reg + 8'h01;
          if (addr_reg == vlk_pkg::REG_DATA_B7) begin
            state_reg <= H_CTRL;
          end
        end
        H_CTRL: state_reg <= H_INDEX;
        H_INDEX: if (ctrl_reg[vlk_pkg::CTRL_RD_BIT]) begin
          addr_reg <= is_dyn ? vlk_pkg::REG_DATA_TOP : vlk_pkg::REG_DATA_B23;
          state_reg <= H_RDREQ;
        end else begin
          state_reg <= H_IDLE;
        end
        H_RDREQ: state_reg <= H_RDWAIT;
        H_RDWAIT: if (mgmt.mgmt_rvalid) begin
          rec_reg[8'(vlk_pkg::REG_DATA_B7 - addr_reg) * 8 +: 8] <= mgmt.mgmt_rdata;
          state_reg <= H_RDREQ;
          if (is_dyn && addr_reg == vlk_pkg::REG_DATA_PMID && mgmt.mgmt_rdata[vlk_pkg::BYTE_NOTREADY_BIT]) begin
            addr_reg <= addr_reg;
          end else if (addr_reg == vlk_pkg::REG_DATA_B7) begin
            state_reg <= H_IDLE;
          end else begin
            addr_reg <= addr_reg + 8'h01;
          end
        end
      endcase
    end
  end

  always_comb begin
    mgmt.mgmt_wr = 1'b0;
    mgmt.mgmt_rd = state_reg == H_RDREQ;
    mgmt.mgmt_addr = addr_reg;
    mgmt.mgmt_wdata = 8'h00;
    unique case (state_reg)
      H_WDATA: begin
        mgmt.mgmt_wr = 1'b1;
        mgmt.mgmt_wdata = 8'({wdata_reg, 2'h0} >> ((vlk_pkg::REG_DATA_B7 - addr_reg) * 8 + 2));
      end
      H_CTRL: begin
        mgmt.mgmt_wr = 1'b1;
        mgmt.mgmt_addr = vlk_pkg::REG_CTRL;
        mgmt.mgmt_wdata = ctrl_reg;
      end
      H_INDEX: begin
        mgmt.mgmt_wr = 1'b1;
        mgmt.mgmt_addr = vlk_pkg::REG_INDEX;
        mgmt.mgmt_wdata = index_reg;
      end
      default: ;
    endcase
  end
endmodule : vlk_host

// ===== vlk_chk.sv
// Checker on the management link between the host end and the device end.
`timescale 1ns/10ps
module vlk_chk (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [7:0] mgmt_wdata,
  input wire logic [7:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  logic [7:0] ctrl_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // The last control byte decides which read sequence must follow the index write.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) ctrl_reg <= 8'h00;
    else if (mgmt_wr && mgmt_addr == vlk_pkg::REG_CTRL) ctrl_reg <= mgmt_wdata;
  end
  AST_RVALID_AFTER_RD: assert property (mgmt_rd |=> mgmt_rvalid)
    else $error("read byte not answered one cycle later");
  AST_NO_STRAY_RVALID: assert property (mgmt_rvalid |-> $past(mgmt_rd))
    else $error("read answer without a read strobe");
  AST_STROBE_EXCL: assert property (!(mgmt_wr && mgmt_rd))
    else $error("write and read strobes together");
  AST_INDEX_AFTER_CTRL: assert property (mgmt_wr && mgmt_addr == vlk_pkg::REG_INDEX |->
    $past(mgmt_wr) && $past(mgmt_addr) == vlk_pkg::REG_CTRL)
    else $error("index write not right after control write");
  AST_DATA_BEFORE_CTRL: assert property (mgmt_wr && mgmt_addr == vlk_pkg::REG_CTRL && !mgmt_wdata[4] |->
    $past(mgmt_wr) && $past(mgmt_addr) == vlk_pkg::REG_DATA_B7)
    else $error("write control byte not preceded by data bytes");
  AST_DATA_ORDER: assert property (mgmt_wr && mgmt_addr == 8'h77 |->
    $past(mgmt_wr) && $past(mgmt_addr) == vlk_pkg::REG_DATA_B23)
    else $error("data bytes out of order");
  AST_NO_DYN_WRITE: assert property (mgmt_wr && mgmt_addr == vlk_pkg::REG_CTRL |->
    mgmt_wdata[4] || mgmt_wdata[3:2] != vlk_pkg::TBL_DYN)
    else $error("write to the dynamic table");
  AST_DYN_READ_START: assert property (mgmt_wr && mgmt_addr == vlk_pkg::REG_INDEX && ctrl_reg[4:2] == 3'b110 |->
    ##[1:8] (mgmt_rd && mgmt_addr == vlk_pkg::REG_DATA_TOP))
    else $error("dynamic read does not start at the top byte");
  AST_VLAN_READ_START: assert property (mgmt_wr && mgmt_addr == vlk_pkg::REG_INDEX && ctrl_reg[4:2] == 3'b101 |->
    ##[1:8] (mgmt_rd && mgmt_addr == vlk_pkg::REG_DATA_B23))
    else $error("VLAN read does not start at bits 21-16");
  AST_REREAD_FROM_PMID: assert property (mgmt_rvalid && mgmt_addr == vlk_pkg::REG_DATA_PMID &&
    mgmt_rdata[vlk_pkg::BYTE_NOTREADY_BIT] |=> mgmt_rd && mgmt_addr == vlk_pkg::REG_DATA_PMID)
    else $error("not-ready byte not reread from bits 55-48");
endmodule : vlk_chk

// ===== vlan_lookup_dyn_mac_table_access_bench.sv
// Self-checking bench joining the host end and the device end.
`timescale 1ns/10ps
module vlan_lookup_dyn_mac_table_access_bench;
  logic core_clk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rlo, rmid, rhi;
  logic awready, wready, bvalid, arready, rvalid, res_valid, res_drop, res_learn;
  logic [1:0] bresp, rresp;
  logic vlan_enable = 1'b0, pkt_valid = 1'b0, pkt_tagged = 1'b0, static_hit = 1'b0;
  logic [59:0] port_default_vid = {36'h0, 12'h123, 12'h000};
  logic [2:0] pkt_port = 3'h0;
  logic [11:0] pkt_tag_vid = 12'h000, res_vid;
  logic [47:0] pkt_da = 48'h0, pkt_sa = 48'h0, s0, s1;
  logic [4:0] static_ports = 5'h00, res_ports;
  logic [15:0] lfsr = 16'hf084;
  logic [21:0] e;
  int bad_count = 0, check_count = 0;
  always #5 core_clk = ~core_clk;
  vlk_mgmt_if mgmt_link ();
  vlk_host i_vlk_host (.core_clk(core_clk), .reset(reset), .mgmt(mgmt_link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // Aging period cut to 1000 cycles, still long enough that learned entries survive the whole run; the small table keeps it quick.
  vlk_device #(.DYN_DEPTH(16), .AGE_CYCLES(1000)) i_vlk_device (.core_clk(core_clk), .reset(reset),
    .mgmt(mgmt_link), .vlan_enable(vlan_enable), .port_default_vid(port_default_vid), .pkt_valid(pkt_valid),
    .pkt_port(pkt_port), .pkt_tagged(pkt_tagged), .pkt_tag_vid(pkt_tag_vid), .pkt_da(pkt_da), .pkt_sa(pkt_sa),
    .static_hit(static_hit), .static_ports(static_ports), .res_valid(res_valid), .res_drop(res_drop),
    .res_ports(res_ports), .res_vid(res_vid), .res_learn(res_learn));
  vlk_chk u_chk (.core_clk(core_clk), .reset(reset), .mgmt_addr(mgmt_link.mgmt_addr), .mgmt_wr(mgmt_link.mgmt_wr),
    .mgmt_rd(mgmt_link.mgmt_rd), .mgmt_wdata(mgmt_link.mgmt_wdata), .mgmt_rdata(mgmt_link.mgmt_rdata),
    .mgmt_rvalid(mgmt_link.mgmt_rvalid));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  function automatic logic [4:0] fwd(input logic [4:0] memb, input logic [2:0] port);
    return memb & ~(5'h01 << port);
  endfunction : fwd
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic hang();
    bad_count++;
    $display("[ERR] %0t wait ran out", $time);
    test_done();
  endtask : hang
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge core_clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      @(posedge core_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ar_t, r_t;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge core_clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      d = rdata;
      @(posedge core_clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask : axi_rd
  // Starts one table access, waits while busy, then fetches the whole record.
  task automatic tbl(input logic [7:0] ctrl, input logic [7:0] idx);
    logic [31:0] st;
    axi_wr(vlk_pkg::AXI_CTRL, {24'h0, ctrl});
    axi_wr(vlk_pkg::AXI_INDEX, {24'h0, idx});
    for (int n = 0; n < 50; n++) begin
      axi_rd(vlk_pkg::AXI_STATUS, st);
      if (st[0] === 1'b0) begin
        axi_rd(vlk_pkg::AXI_REC_LO, rlo);
        axi_rd(vlk_pkg::AXI_REC_MID, rmid);
        axi_rd(vlk_pkg::AXI_REC_HI, rhi);
        return;
      end
    end
    hang();
  endtask : tbl
  task automatic vlan_wr(input logic [7:0] idx, input logic [21:0] ent);
    axi_wr(vlk_pkg::AXI_WDATA, {10'h0, ent});
    tbl(8'h04, idx);
  endtask : vlan_wr
  task automatic pkt(input logic [2:0] p, input logic tg, input logic [11:0] v, input logic [47:0] sa,
                     input logic [4:0] xp, input logic xd, input logic xl, input logic [11:0] xv);
    @(posedge core_clk);
    pkt_valid <= 1'b1;
    pkt_port <= p;
    pkt_tagged <= tg;
    pkt_tag_vid <= v;
    pkt_sa <= sa;
    pkt_da <= {rnd(), rnd(), rnd()};
    @(posedge core_clk);
    pkt_valid <= 1'b0;
    @(negedge core_clk);
    chk({res_valid, res_drop, res_learn, res_vid & {12{vlan_enable}}, res_ports}, {1'b1, xd, xl, xv, xp});
  endtask : pkt
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    tbl(8'h14, 8'h00);
    chk(rlo[21:0], vlk_pkg::VLAN_RESET);
    tbl(8'h14, 8'h0f);
    chk(rlo[21:0], vlk_pkg::VLAN_RESET);
    tbl(8'h18, 8'h00);
    chk({rhi[4:0], rmid[31:26], rmid[23]}, {5'h10, 6'h00, 1'b0});
    $display("test reset_defaults done");
    for (int i = 4; i < 16; i += 3) begin
      e = 22'({rnd(), rnd()});
      vlan_wr(i[7:0], e);
      tbl(8'h14, i[7:0]);
      chk(rlo[21:0], e);
    end
    $display("test vlan_readback done");
    vlan_wr(8'h02, {1'b1, 5'b11001, 4'h5, 12'h123});
    vlan_wr(8'h03, {1'b0, 5'h1f, 4'h2, 12'h0aa});
    // Low nibbles cleared so the two learned pairs land in different slots.
    s0 = {rnd(), rnd(), rnd()} & 48'hffff_ffff_fff0;
    s1 = {rnd(), rnd(), rnd()} & 48'hffff_ffff_fff0;
    pkt(3'h4, 1'b1, 12'h0aa, s0, fwd(5'h1f, 3'h4), 1'b0, 1'b1, 12'h000);
    @(posedge core_clk);
    vlan_enable <= 1'b1;
    pkt(3'h1, 1'b0, 12'h000, s1, fwd(5'b11001, 3'h1), 1'b0, 1'b1, 12'h123);
    pkt(3'h1, 1'b1, 12'h000, s1, fwd(5'b11001, 3'h1), 1'b0, 1'b0, 12'h123);
    @(posedge core_clk);
    static_hit <= 1'b1;
    static_ports <= 5'b00100;
    pkt(3'h1, 1'b1, 12'h123, s1, 5'b00100, 1'b0, 1'b0, 12'h123);
    @(posedge core_clk);
    static_hit <= 1'b0;
    pkt(3'h4, 1'b1, 12'h123, s1, fwd(5'b11001, 3'h4), 1'b0, 1'b0, 12'h123);
    pkt(3'h0, 1'b1, 12'h0aa, {rnd(), rnd(), rnd()}, 5'h00, 1'b1, 1'b0, 12'h0aa);
    $display("test lookup done");
    tbl(8'h18, 8'h05);
    chk({rhi[4:0], rmid[31:26]}, {1'b0, 10'h001});
    chk({rmid[23:16], rmid[15:0], rlo}, {1'b0, 3'h4, 4'h5, s1});
    tbl(8'h18, 8'h00);
    chk({rmid[23:16], rmid[15:0], rlo}, {1'b0, 3'h4, 4'h0, s0});
    $display("test dynamic_read done");
    test_done();
  end
  initial begin
    repeat (50000) @(posedge core_clk);
    hang();
  end
endmodule : vlan_lookup_dyn_mac_table_access_bench
